//--- rtl/lbrec_defs.svh
// Register offsets, field positions, reset values and timing counts of the bias rail control.
`ifndef LBREC_DEFS_SVH
`define LBREC_DEFS_SVH

// =============================================================
// Register offsets
`define LBREC_ADDR_CTRL       8'h0c
`define LBREC_ADDR_POS_CODE   8'h0d
`define LBREC_ADDR_NEG_CODE   8'h0e
`define LBREC_ADDR_BOOST_CODE 8'h0f
`define LBREC_ADDR_FLAGS      8'h10

// =============================================================
// Control register fields
`define LBREC_CTRL_SRC_BIT    0
`define LBREC_CTRL_NEG_EN_BIT 1
`define LBREC_CTRL_POS_EN_BIT 2
`define LBREC_CTRL_NEG_DIS_BIT 3
`define LBREC_CTRL_POS_DIS_BIT 4
`define LBREC_CTRL_SEQ_BIT    5
`define LBREC_CTRL_WAKE_BIT   7
`define LBREC_CTRL_RW_MASK    8'hbf
`define LBREC_CTRL_RESET      8'h00

// =============================================================
// Flag register fields
`define LBREC_FLAG_BACKLIGHT_OVERCURRENT_FLAG_BIT    0
`define LBREC_FLAG_NEG_GND_BIT   2
`define LBREC_FLAG_POS_OCP_BIT   3
`define LBREC_FLAG_NEG_OVP_BIT   4
`define LBREC_FLAG_BOOST_OVP_BIT 5
`define LBREC_FLAGS_RESET        8'h00

// =============================================================
// Voltage codes: base and step in millivolts, highest legal code
`define LBREC_STEP_MV        50
`define LBREC_POS_BASE_MV    4000
`define LBREC_NEG_BASE_MV    -6000
`define LBREC_BOOST_BASE_MV  4500
`define LBREC_POS_CODE_MAX   6'h28
`define LBREC_NEG_CODE_MAX   6'h28
`define LBREC_BOOST_CODE_MAX 6'h26
`define LBREC_CODE_RESET     6'h00

// =============================================================
// Timing
`define LBREC_CLK_MHZ        20
`define LBREC_SEQ_ON_US      100
`define LBREC_SEQ_OFF_US     100
`define LBREC_SEQ_ON_CYC     (`LBREC_SEQ_ON_US * `LBREC_CLK_MHZ)
`define LBREC_SEQ_OFF_CYC    (`LBREC_SEQ_OFF_US * `LBREC_CLK_MHZ)

`endif

//--- rtl/lbrec_pkg.sv
// Types shared by the bias rail control.
package lbrec_pkg;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RAMP_UP,
        SEQ_ALL_ON,
        SEQ_RAMP_DOWN
    } lbrec_seq_e;

    typedef logic [15:0] lbrec_cnt_t;
endpackage

//--- rtl/lbrec_top.sv
// Bias rail enable, sequencing, voltage code hand-off and fault flag logic.
`timescale 1ns/1ps
`include "lbrec_defs.svh"

// Behaviour
// R01: Control bit 0 low selects rail pins, high selects register enable bits.
// R02: Master enable pin low forces whole bias section into shutdown.
// R03: Pin mode: first pin drives positive rail, second pin negative rail.
// R04: Register mode: bit 2 drives positive rail, bit 1 drives negative rail.
// R05: Sequencing bit clear: rails switch independently of each other.
// R06: Sequencing bit set with both rails requested: device orders on and off.
// R07: Wake-up bit: second pin gates register enable bits, source bit ignored.
// R08: Rail voltage codes take effect only after the rail cycles off and on.
// R09: Boost voltage code takes effect immediately on write.
// R10: Positive code spans 4 V to 6 V in 50 mV steps.
// R11: Negative code spans -6 V to -4 V in 50 mV steps.
// R12: Boost code spans 4.5 V to 6.4 V in 50 mV steps.
// R13: Control bits 4 and 3 enable positive and negative active discharge.
// R14: Host waits 1 ms between negative rail off and on with discharge.
// R15: Boost overvoltage sets flag bit 5, cleared by read, rails keep running.
// R16: Negative overvoltage sets flag bit 4, cleared by read, pump keeps running.
// R17: Positive overcurrent sets flag bit 3, cleared by read, no shutdown.
// R18: Negative rail near ground sets flag bit 2, cleared by read, no shutdown.
// R19: Bias faults only set their own flags, nothing else changes.
// R20: Reading the flag register also clears backlight overcurrent bit 0.
// R21: Auto sequence: positive on first, off last, delays configurable.
// R22: A fault still present after a read sets its flag again.
module lbrec_top #(
    parameter int CODE_W      = 6,
    parameter int SEQ_ON_CYC  = `LBREC_SEQ_ON_CYC,
    parameter int SEQ_OFF_CYC = `LBREC_SEQ_OFF_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              master_enable_pin,
    input  wire logic              positive_rail_enable_pin,
    input  wire logic              negative_rail_enable_pin,
    input  wire logic              boost_ovp_detect,
    input  wire logic              neg_ovp_detect,
    input  wire logic              pos_ocp_detect,
    input  wire logic              neg_gnd_detect,
    input  wire logic              backlight_ocp_event,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic      [7:0]        reg_rdata,
    output logic                   bias_shutdown,
    output logic                   bias_standby,
    output logic                   positive_rail_on,
    output logic                   negative_rail_on,
    output logic                   positive_discharge_en,
    output logic                   negative_discharge_en,
    output logic      [CODE_W-1:0] positive_rail_code,
    output logic      [CODE_W-1:0] negative_rail_code,
    output logic      [CODE_W-1:0] bias_boost_output_code
);

    // =============================================================
    // Parameter checks
    if (CODE_W < 6 || CODE_W > 8) begin : g_bad_width
        $error("CODE_W must be 6 to 8");
    end
    if (SEQ_ON_CYC < 1 || SEQ_OFF_CYC < 1 ||
        SEQ_ON_CYC > 65535 || SEQ_OFF_CYC > 65535) begin : g_bad_delay
        $error("Sequencing delays must be 1 to 65535 cycles");
    end

    localparam lbrec_pkg::lbrec_cnt_t ON_LOAD  = lbrec_pkg::lbrec_cnt_t'(SEQ_ON_CYC - 1);
    localparam lbrec_pkg::lbrec_cnt_t OFF_LOAD = lbrec_pkg::lbrec_cnt_t'(SEQ_OFF_CYC - 1);

    // =============================================================
    // Pin and comparator synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NSYNC-1:0] async_in;

    assign async_in = {neg_gnd_detect, pos_ocp_detect, neg_ovp_detect, boost_ovp_detect,
                       negative_rail_enable_pin, positive_rail_enable_pin, master_enable_pin};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    logic master_s;
    logic pos_pin_s;
    logic neg_pin_s;
    logic [3:0] fault_s;
    assign master_s  = sync2_q[0];
    assign pos_pin_s = sync2_q[1];
    assign neg_pin_s = sync2_q[2];
    assign fault_s   = sync2_q[6:3];

    // =============================================================
    // Register file
    logic [7:0]        ctrl_q;
    logic [CODE_W-1:0] pos_code_q;
    logic [CODE_W-1:0] neg_code_q;
    logic [CODE_W-1:0] boost_code_q;
    logic [7:0]        flags_q;
    logic [7:0]        rdata_q;

    // Codes above the top of a range saturate at the highest legal step.
    function automatic logic [CODE_W-1:0] clamp_code(input logic [7:0] v,
                                                     input logic [5:0] max);
        logic [CODE_W-1:0] r;
        r = (v > {2'b00, max}) ? CODE_W'(max) : CODE_W'(v);
        return r;
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= `LBREC_CTRL_RESET;
        end else if (reg_wr && reg_addr == `LBREC_ADDR_CTRL) begin
            ctrl_q <= reg_wdata & `LBREC_CTRL_RW_MASK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_code_q   <= CODE_W'(`LBREC_CODE_RESET);
            neg_code_q   <= CODE_W'(`LBREC_CODE_RESET);
            boost_code_q <= CODE_W'(`LBREC_CODE_RESET);
        end else if (reg_wr) begin
            if (reg_addr == `LBREC_ADDR_POS_CODE) begin
                pos_code_q <= clamp_code(reg_wdata, `LBREC_POS_CODE_MAX); // see R10
            end
            if (reg_addr == `LBREC_ADDR_NEG_CODE) begin
                neg_code_q <= clamp_code(reg_wdata, `LBREC_NEG_CODE_MAX); // see R11
            end
            if (reg_addr == `LBREC_ADDR_BOOST_CODE) begin
                boost_code_q <= clamp_code(reg_wdata, `LBREC_BOOST_CODE_MAX); // see R12
            end
        end
    end

    logic flags_rd;
    assign flags_rd = reg_rd && reg_addr == `LBREC_ADDR_FLAGS;

    // A detection in the very cycle of the read wins, so no event is lost.
    // Faults touch nothing but these bits.
    logic [7:0] flag_set;
    always_comb begin
        flag_set                            = 8'h00;
        flag_set[`LBREC_FLAG_BACKLIGHT_OVERCURRENT_FLAG_BIT]    = backlight_ocp_event;
        flag_set[`LBREC_FLAG_NEG_GND_BIT]   = fault_s[3]; // see R18
        flag_set[`LBREC_FLAG_POS_OCP_BIT]   = fault_s[2]; // see R17
        flag_set[`LBREC_FLAG_NEG_OVP_BIT]   = fault_s[1]; // see R16
        flag_set[`LBREC_FLAG_BOOST_OVP_BIT] = fault_s[0]; // see R15
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_q <= `LBREC_FLAGS_RESET;
        end else begin
            flags_q <= flag_set | (flags_rd ? 8'h00 : flags_q); // see R19, see R20, see R22
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LBREC_ADDR_CTRL:       rdata_q <= ctrl_q;
                `LBREC_ADDR_POS_CODE:   rdata_q <= 8'(pos_code_q);
                `LBREC_ADDR_NEG_CODE:   rdata_q <= 8'(neg_code_q);
                `LBREC_ADDR_BOOST_CODE: rdata_q <= 8'(boost_code_q);
                `LBREC_ADDR_FLAGS:      rdata_q <= flags_q;
                default:                rdata_q <= 8'h00;
            endcase
        end
    end
    assign reg_rdata = rdata_q;

    // =============================================================
    // Rail requests
    logic pos_req;
    logic neg_req;
    logic auto_both;

    always_comb begin
        if (ctrl_q[`LBREC_CTRL_WAKE_BIT]) begin
            pos_req = neg_pin_s && ctrl_q[`LBREC_CTRL_POS_EN_BIT]; // see R07
            neg_req = neg_pin_s && ctrl_q[`LBREC_CTRL_NEG_EN_BIT]; // see R07
        end else if (!ctrl_q[`LBREC_CTRL_SRC_BIT]) begin // see R01
            pos_req = pos_pin_s; // see R03
            neg_req = neg_pin_s; // see R03
        end else begin
            pos_req = ctrl_q[`LBREC_CTRL_POS_EN_BIT]; // see R04
            neg_req = ctrl_q[`LBREC_CTRL_NEG_EN_BIT]; // see R04
        end
    end

    assign auto_both = ctrl_q[`LBREC_CTRL_SEQ_BIT] && pos_req && neg_req;

    // =============================================================
    // Auto sequencer
    lbrec_pkg::lbrec_seq_e state_q;
    lbrec_pkg::lbrec_cnt_t cnt_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= lbrec_pkg::SEQ_IDLE;
            cnt_q   <= '0;
        end else if (!master_s) begin
            state_q <= lbrec_pkg::SEQ_IDLE; // see R02
            cnt_q   <= '0;
        end else begin
            unique case (state_q)
                lbrec_pkg::SEQ_IDLE: begin
                    if (auto_both) begin
                        state_q <= lbrec_pkg::SEQ_RAMP_UP; // see R06
                        cnt_q   <= ON_LOAD;
                    end
                end
                lbrec_pkg::SEQ_RAMP_UP: begin
                    if (!auto_both) begin
                        state_q <= lbrec_pkg::SEQ_IDLE;
                    end else if (cnt_q == '0) begin
                        state_q <= lbrec_pkg::SEQ_ALL_ON;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                lbrec_pkg::SEQ_ALL_ON: begin
                    if (!auto_both) begin
                        state_q <= lbrec_pkg::SEQ_RAMP_DOWN; // see R21
                        cnt_q   <= OFF_LOAD;
                    end
                end
                lbrec_pkg::SEQ_RAMP_DOWN: begin
                    if (cnt_q == '0) begin
                        state_q <= lbrec_pkg::SEQ_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Positive rail leads on power-up and trails on power-down.
    logic pos_d;
    logic neg_d;
    always_comb begin
        unique case (state_q)
            lbrec_pkg::SEQ_IDLE: begin
                pos_d = pos_req;
                neg_d = neg_req && !auto_both; // see R05
            end
            lbrec_pkg::SEQ_RAMP_UP: begin
                pos_d = 1'b1; // see R21
                neg_d = 1'b0;
            end
            lbrec_pkg::SEQ_ALL_ON: begin
                pos_d = 1'b1;
                neg_d = auto_both;
            end
            lbrec_pkg::SEQ_RAMP_DOWN: begin
                pos_d = 1'b1; // see R21
                neg_d = 1'b0;
            end
        endcase
    end

    // =============================================================
    // Rail outputs and voltage code hand-off
    logic pos_on_q;
    logic neg_on_q;
    logic shutdown_q;
    logic standby_q;
    logic pos_dis_q;
    logic neg_dis_q;
    logic [CODE_W-1:0] pos_active_q;
    logic [CODE_W-1:0] neg_active_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_on_q   <= 1'b0;
            neg_on_q   <= 1'b0;
            shutdown_q <= 1'b1;
            standby_q  <= 1'b0;
        end else begin
            pos_on_q   <= master_s && pos_d; // see R02
            neg_on_q   <= master_s && neg_d; // see R02
            shutdown_q <= !master_s;
            standby_q  <= master_s && !pos_d && !neg_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_dis_q <= 1'b0;
            neg_dis_q <= 1'b0;
        end else begin
            pos_dis_q <= ctrl_q[`LBREC_CTRL_POS_DIS_BIT]; // see R13
            neg_dis_q <= ctrl_q[`LBREC_CTRL_NEG_DIS_BIT]; // see R13
        end
    end

    // A rail keeps the code it started with; a new code is picked up while it is off.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_active_q <= CODE_W'(`LBREC_CODE_RESET);
            neg_active_q <= CODE_W'(`LBREC_CODE_RESET);
        end else begin
            if (!pos_on_q) begin
                pos_active_q <= pos_code_q; // see R08
            end
            if (!neg_on_q) begin
                neg_active_q <= neg_code_q; // see R08
            end
        end
    end

    assign bias_shutdown          = shutdown_q;
    assign bias_standby           = standby_q;
    assign positive_rail_on       = pos_on_q;
    assign negative_rail_on       = neg_on_q;
    assign positive_discharge_en  = pos_dis_q;
    assign negative_discharge_en  = neg_dis_q;
    assign positive_rail_code     = pos_active_q;
    assign negative_rail_code     = neg_active_q;
    assign bias_boost_output_code = boost_code_q; // see R09

    // =============================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_SHUTDOWN_OFF: assert property (!master_s |=> !pos_on_q && !neg_on_q && shutdown_q) // see R02
        else $error("Rails on while master enable low");
    AST_PIN_MODE_POS: assert property ((master_s && ctrl_q == 8'h00)
        |=> pos_on_q == $past(pos_pin_s) && neg_on_q == $past(neg_pin_s)) // see R03
        else $error("Pin mode rails do not follow pins");
    AST_REG_MODE: assert property ((master_s && ctrl_q[7:5] == 3'b000 && ctrl_q[0])
        |=> pos_on_q == $past(ctrl_q[2]) && neg_on_q == $past(ctrl_q[1])) // see R04
        else $error("Register mode rails do not follow enable bits");
    AST_WAKE_STANDBY: assert property ((master_s && ctrl_q[7] && !neg_pin_s)
        |=> !pos_on_q && !neg_on_q) // see R07
        else $error("Wake-up mode rail on with second pin low");
    AST_SEQ_POS_FIRST: assert property ((master_s && state_q == lbrec_pkg::SEQ_IDLE && auto_both)
        ##1 (master_s && auto_both)[*2] |-> pos_on_q && !neg_on_q) // see R21
        else $error("Auto sequence did not lead with positive rail");
    AST_SEQ_NEG_OFF_FIRST: assert property ((master_s && state_q == lbrec_pkg::SEQ_ALL_ON
        && !auto_both) ##1 master_s |=> pos_on_q && !neg_on_q) // see R06
        else $error("Auto sequence did not drop negative rail first");
    AST_CODE_HELD: assert property ((pos_on_q && $past(pos_on_q))
        |-> pos_active_q == $past(pos_active_q)) // see R08
        else $error("Positive code changed while rail on");
    AST_BOOST_NOW: assert property ((reg_wr && reg_addr == `LBREC_ADDR_BOOST_CODE
        && reg_wdata <= 8'h26) |=> bias_boost_output_code == CODE_W'($past(reg_wdata))) // see R09
        else $error("Boost code not applied at once");
    AST_FLAG_SET_WINS: assert property ((fault_s[0] && flags_rd) |=> flags_q[5]) // see R15
        else $error("Boost overvoltage flag lost on read");
    AST_READ_CLEARS: assert property ((flags_rd && flag_set == 8'h00) |=> flags_q == 8'h00) // see R20
        else $error("Flag read did not clear flags");
    AST_FAULT_NO_EFFECT: assert property ((master_s && ctrl_q[7:5] == 3'b000 && ctrl_q[0]
        && fault_s != 4'h0) |=> pos_on_q == $past(ctrl_q[2])) // see R19
        else $error("Bias fault changed rail state");

    COV_AUTO_FULL: cover property (state_q == lbrec_pkg::SEQ_RAMP_DOWN ##1
        state_q == lbrec_pkg::SEQ_IDLE);
    COV_WAKE_ON: cover property (ctrl_q[7] && pos_on_q && neg_on_q);
    COV_READ_CLEAR: cover property (flags_q[4] ##1 flags_rd ##1 flags_q == 8'h00);

endmodule

//--- tb/lbrec_host_model.sv
// Host model: drives the master and rail enable pins and the register strobes.
`timescale 1ns/1ps
module lbrec_host_model #(
    parameter int NEG_REARM_CYC = 20000
) (
    input  wire logic       clk,
    output logic            master_enable_pin,
    output logic            positive_rail_enable_pin,
    output logic            negative_rail_enable_pin,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       negative_rail_on,
    input  wire logic       negative_discharge_en
);
    int unsigned off_cnt = NEG_REARM_CYC;

    initial begin
        master_enable_pin = 1'b0;
        positive_rail_enable_pin = 1'b0;
        negative_rail_enable_pin = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // =============================================================
    // Negative rail re-arm guard
    // A discharging rail switched back on too soon is unsafe, so pin changes and register writes wait; reads do not.
    always @(posedge clk) begin
        if (negative_rail_on) begin
            off_cnt <= 0;
        end else if (off_cnt < NEG_REARM_CYC) begin
            off_cnt <= off_cnt + 1;
        end
    end

    task automatic rearm_wait();
        while (negative_discharge_en === 1'b1 && negative_rail_on !== 1'b1 &&
               off_cnt < NEG_REARM_CYC) begin
            @(negedge clk);
        end
    endtask

    // =============================================================
    // Requests
    task automatic set_pins(input logic m, input logic p, input logic n);
        rearm_wait();
        @(negedge clk);
        master_enable_pin = m;
        positive_rail_enable_pin = p;
        negative_rail_enable_pin = n;
    endtask

    // Released address and data are inverted so stale values are never seen as held.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        rearm_wait();
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the bias rail enable control.
`timescale 1ns/1ps
module tb_top;
    localparam int         CEIL    = 80000;
    localparam logic [5:0] POS_TOP = 6'((6000 - 4000) / 50);
    localparam logic [5:0] NEG_TOP = 6'((6000 - 4000) / 50);
    localparam logic [5:0] BST_TOP = 6'((6400 - 4500) / 50);
    logic       clk;
    logic       sys_rst;
    logic       mst_pin, pos_pin, neg_pin, reg_wr, reg_rd, bl_evt;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [3:0] fault;
    logic       shut, stby, pos_on, neg_on, pos_dis, neg_dis;
    logic [5:0] pos_code, neg_code, bst_code;
    logic [3:0] sts;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    assign sts = {shut, stby, pos_on, neg_on};

    lbrec_top #(.SEQ_ON_CYC(4), .SEQ_OFF_CYC(4)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .master_enable_pin(mst_pin),
        .positive_rail_enable_pin(pos_pin), .negative_rail_enable_pin(neg_pin),
        .boost_ovp_detect(fault[3]), .neg_ovp_detect(fault[2]),
        .pos_ocp_detect(fault[1]), .neg_gnd_detect(fault[0]), .backlight_ocp_event(bl_evt),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .bias_shutdown(shut), .bias_standby(stby),
        .positive_rail_on(pos_on), .negative_rail_on(neg_on),
        .positive_discharge_en(pos_dis), .negative_discharge_en(neg_dis),
        .positive_rail_code(pos_code), .negative_rail_code(neg_code),
        .bias_boost_output_code(bst_code));

    lbrec_host_model #(.NEG_REARM_CYC(20000)) host_u (
        .clk(clk), .master_enable_pin(mst_pin), .positive_rail_enable_pin(pos_pin),
        .negative_rail_enable_pin(neg_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .negative_rail_on(neg_on), .negative_discharge_en(neg_dis));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =============================================================
    // Helpers
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == CEIL) begin
            err_total++;
            $display("mismatch at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rails(input logic [3:0] exp, input string what);
        chk({4'h0, sts}, {4'h0, exp}, what);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.reg_read(a, rv);
        chk(rv, exp, "register read");
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait on one status bit; a missed edge shows up as a mismatch.
    task automatic wait_bit(input int idx, input logic v);
        int n;
        n = 0;
        while (sts[idx] !== v && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk({7'h0, sts[idx]}, {7'h0, v}, "rail edge");
    endtask

    // =============================================================
    // Scenarios
    task automatic t_regs();
        rails(4'h8, "shutdown after reset");
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h20, 8'h00);
        host_u.reg_write(8'h0c, 8'hff);
        host_u.reg_write(8'h20, 8'h00);
        rd_chk(8'h0c, 8'hbf);
        rails(4'h8, "master low overrides");
        host_u.reg_write(8'h0c, 8'h00);
    endtask

    task automatic t_modes();
        logic [1:0] r;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 4; i++) begin
                r = 2'(i);
                if (s == 0) host_u.set_pins(1'b1, r[1], r[0]);
                else host_u.reg_write(8'h0c, {5'h0, r, 1'b1});
                idle(4);
                rails({1'b0, r == 2'b00, r}, "rail select");
            end
        end
    endtask

    task automatic t_wake();
        host_u.set_pins(1'b1, 1'b1, 1'b0);
        host_u.reg_write(8'h0c, 8'h86);
        idle(4);
        rails(4'h4, "wake pin low");
        host_u.set_pins(1'b1, 1'b0, 1'b1);
        idle(4);
        rails(4'h3, "wake pin high");
    endtask

    task automatic t_seq();
        host_u.reg_write(8'h0c, 8'h01);
        idle(3);
        host_u.reg_write(8'h0c, 8'h27);
        wait_bit(1, 1'b1);
        rails(4'h2, "positive first");
        idle(2);
        rails(4'h2, "negative held back");
        wait_bit(0, 1'b1);
        host_u.reg_write(8'h0c, 8'h21);
        wait_bit(0, 1'b0);
        rails(4'h2, "positive still on");
        idle(2);
        rails(4'h2, "positive held on");
        wait_bit(1, 1'b0);
        rails(4'h4, "standby after ramp down");
    endtask

    task automatic t_dis();
        for (int i = 1; i < 4; i++) begin
            host_u.reg_write(8'h0c, 8'(i << 3));
            idle(3);
            chk({6'h0, pos_dis, neg_dis}, 8'(i), "discharge select");
        end
        host_u.reg_write(8'h0c, 8'h01);
    endtask

    task automatic t_codes();
        host_u.reg_write(8'h0c, 8'h05);
        idle(3);
        host_u.reg_write(8'h0d, {2'h0, POS_TOP});
        host_u.reg_write(8'h0e, {2'h0, NEG_TOP});
        host_u.reg_write(8'h0f, {2'h0, BST_TOP});
        idle(3);
        chk({2'h0, pos_code}, 8'h00, "code frozen while on");
        chk({2'h0, neg_code}, {2'h0, NEG_TOP}, "code loads while off");
        chk({2'h0, bst_code}, {2'h0, BST_TOP}, "boost code at once");
        host_u.reg_write(8'h0c, 8'h01);
        idle(3);
        host_u.reg_write(8'h0c, 8'h05);
        idle(3);
        chk({2'h0, pos_code}, {2'h0, POS_TOP}, "code after off-on");
        host_u.reg_write(8'h0f, 8'h3f);
        idle(3);
        chk({2'h0, bst_code}, {2'h0, BST_TOP}, "boost code ceiling");
    endtask

    task automatic t_faults();
        host_u.reg_write(8'h0c, 8'h07);
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        idle(4);
        rails(4'h8, "master low");
        host_u.set_pins(1'b1, 1'b0, 1'b0);
        idle(4);
        for (int i = 0; i < 4; i++) begin
            fault = 4'(1 << i);
            idle(5);
            rails(4'h3, "rails through fault");
            rd_chk(8'h10, 8'(8'h04 << i));
            rd_chk(8'h10, 8'(8'h04 << i));
            fault = 4'h0;
            idle(5);
            rd_chk(8'h10, 8'(8'h04 << i));
            rd_chk(8'h10, 8'h00);
        end
        fault = 4'h1;
        bl_evt = 1'b1;
        idle(1);
        bl_evt = 1'b0;
        idle(5);
        fault = 4'h0;
        idle(5);
        rd_chk(8'h10, 8'h05);
        rd_chk(8'h10, 8'h00);
    endtask

    initial begin
        sys_rst = 1'b1;
        fault = 4'h0;
        bl_evt = 1'b0;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        idle(1);
        t_regs();
        t_modes();
        t_wake();
        t_seq();
        t_dis();
        t_codes();
        t_faults();
        end_of_test();
    end
endmodule
